// ---- design/scm_correction_math.v ----
`include "scm_defines.vh"
// ************************************
// Correction datapath
// ************************************
module scm_correction_math (
	// Clock and reset
	input  wire               ref_clk,
	input  wire               reset_n,
	input  wire               clk_en,
	// Raw readings
	input  wire signed [17:0] raw_bridge,
	input  wire               bridge_valid,
	input  wire signed [17:0] raw_temp,
	input  wire               temp_valid,
	// Coefficients
	input  wire               curve_shape_select,
	input  wire signed [17:0] gain_b,
	input  wire signed [17:0] offset_b,
	input  wire signed [17:0] tc_gain,
	input  wire signed [17:0] tc_offset,
	input  wire signed [17:0] low_cal_temperature_ref,
	input  wire signed [17:0] gain_drift_quad_coef,
	input  wire signed [17:0] offset_drift_quad_coef,
	input  wire signed [17:0] bridge_quad_coef,
	input  wire signed [17:0] gain_t,
	input  wire signed [17:0] offset_t,
	input  wire signed [17:0] temp_quad_coef,
	// Results
	output wire               busy,
	output reg                done,
	output reg         [15:0] bridge_out,
	output reg         [7:0]  bridge_status,
	output reg         [16:0] temp_out,
	output reg         [7:0]  temp_status
);
	// ************************************
	// Sequencer and working registers
	// ************************************
	reg        [3:0]  step;
	reg        [3:0]  next_step;
	reg signed [17:0] delta_t;
	reg signed [17:0] gain_drift_factor;
	reg signed [17:0] offset_corrected_bridge;
	reg signed [17:0] acc;
	reg signed [17:0] bridge_stage_one_value;
	reg signed [17:0] zt;
	reg               sat_b;
	reg               sat_t;
	// Multiplier operands
	reg signed [17:0] m_a;
	reg signed [17:0] m_b;
	reg signed [17:0] m_lo;
	reg signed [17:0] m_hi;
	reg               m_sh;
	wire signed [17:0] m_res;
	wire               m_sat;
	// Adder path
	reg signed [18:0] sum;
	reg signed [17:0] add_a;
	reg signed [17:0] add_b;
	reg signed [17:0] add_lo;
	reg signed [17:0] add_hi;
	reg signed [17:0] add_res;
	reg               add_sat;
	reg               use_add;
	reg signed [17:0] step_res;
	reg               step_sat;
	assign busy  = (step != `SCM_ST_IDLE);
	scm_sat_mul u_mul (
		.op_a     (m_a),
		.op_b     (m_b),
		.lo_lim   (m_lo),
		.hi_lim   (m_hi),
		.do_shift (m_sh),
		.res      (m_res),
		.sat      (m_sat)
	);

	// ************************************
	// Step operand selection
	// ************************************
	// One multiplier shared across steps: area traded for eleven cycles latency
	always @* begin
		m_a = 18'sh00000;
		m_b = 18'sh00000;
		m_lo = `SCM_MIN;
		m_hi = `SCM_MAX;
		m_sh = 1'b1;
		add_a = 18'sh00000;
		add_b = 18'sh00000;
		add_lo = `SCM_MIN;
		add_hi = `SCM_MAX;
		use_add = 1'b0;
		case (step)
			4'h1: begin
				add_a = raw_temp;
				add_b = -low_cal_temperature_ref;
				use_add = 1'b1;
			end
			4'h2: begin
				m_a = gain_drift_quad_coef;
				m_b = delta_t;
				add_a = m_res;
				add_b = tc_gain;
				use_add = 1'b1;
			end
			4'h3: begin
				m_a = delta_t;
				m_b = acc;
				add_a = m_res;
				add_b = `SCM_HALF;
				use_add = 1'b1;
			end
			4'h4: begin
				m_a = offset_drift_quad_coef;
				m_b = delta_t;
				add_a = m_res;
				add_b = tc_offset;
				use_add = 1'b1;
			end
			4'h5: begin
				m_a = delta_t;
				m_b = acc;
				add_a = m_res;
				add_b = raw_bridge;
				use_add = 1'b1;
			end
			4'h6: begin
				add_a = offset_b;
				add_b = acc;
				use_add = 1'b1;
			end
			4'h7: begin
				m_a = gain_drift_factor;
				m_b = offset_corrected_bridge;
			end
			4'h8: begin
				m_a = gain_b;
				m_b = acc;
				add_a = m_res;
				add_b = curve_shape_select ? 18'sh00000 : `SCM_HALF;
				add_lo = curve_shape_select ? `SCM_MIN : 18'sh00000;
				use_add = 1'b1;
			end
			4'h9: begin
				m_a = (curve_shape_select && bridge_stage_one_value[17]) ?
					-bridge_quad_coef : bridge_quad_coef;
				m_b = bridge_stage_one_value;
				add_a = m_res;
				add_b = `SCM_HALF;
				use_add = 1'b1;
			end
			4'ha: begin
				m_a = bridge_stage_one_value;
				m_b = acc;
				m_lo = curve_shape_select ? `SCM_MIN : 18'sh00000;
				add_a = m_res;
				add_b = curve_shape_select ? `SCM_HALF : 18'sh00000;
				add_lo = 18'sh00000;
				add_hi = curve_shape_select ? `SCM_B_MAX : `SCM_MAX;
				use_add = 1'b1;
			end
			default: use_add = 1'b0;
		endcase
		sum = {add_a[17], add_a} + {add_b[17], add_b};
		if (sum > $signed({add_hi[17], add_hi})) begin
			add_res = add_hi;
			add_sat = 1'b1;
		end else if (sum < $signed({add_lo[17], add_lo})) begin
			add_res = add_lo;
			add_sat = 1'b1;
		end else begin
			add_res = sum[17:0];
			add_sat = 1'b0;
		end
		step_res = use_add ? add_res : m_res;
		step_sat = m_sat | (use_add & add_sat);
	end
	// Temperature path, combinational on its own stored stage
	reg signed [17:0] t_sum;
	reg               t_sat_a;
	wire signed [17:0] t_m1;
	wire               t_s1;
	wire signed [17:0] t_m2;
	wire               t_s2;
	reg signed [18:0] t_s19;
	reg signed [17:0] t_q;
	reg               t_sat_q;
	wire signed [17:0] t_fin;
	wire               t_s3;
	scm_sat_mul u_t1 (
		.op_a     (gain_t),
		.op_b     (t_sum),
		.lo_lim   (`SCM_MIN),
		.hi_lim   (`SCM_MAX),
		.do_shift (1'b1),
		.res      (t_m1),
		.sat      (t_s1)
	);
	scm_sat_mul u_t2 (
		.op_a     (temp_quad_coef),
		.op_b     (zt),
		.lo_lim   (`SCM_MIN),
		.hi_lim   (`SCM_MAX),
		.do_shift (1'b1),
		.res      (t_m2),
		.sat      (t_s2)
	);
	scm_sat_mul u_t3 (
		.op_a     (zt),
		.op_b     (t_q),
		.lo_lim   (18'sh00000),
		.hi_lim   (`SCM_MAX),
		.do_shift (1'b1),
		.res      (t_fin),
		.sat      (t_s3)
	);
	always @* begin
		t_s19 = {raw_temp[17], raw_temp} + {offset_t[17], offset_t};
		if (t_s19 > 19'sh1ffff) begin
			t_sum = `SCM_MAX;
			t_sat_a = 1'b1;
		end else if (t_s19 < -19'sh20000) begin
			t_sum = `SCM_MIN;
			t_sat_a = 1'b1;
		end else begin
			t_sum = t_s19[17:0];
			t_sat_a = 1'b0;
		end
		t_s19 = {t_m2[17], t_m2} + 19'sh08000;
		if (t_s19 > 19'sh1ffff) begin
			t_q = `SCM_MAX;
			t_sat_q = 1'b1;
		end else begin
			t_q = t_s19[17:0];
			t_sat_q = 1'b0;
		end
	end
	// First temperature stage with clamp to positive range
	reg signed [18:0] zt_sum;
	reg signed [17:0] next_zt;
	reg               zt_sat;
	always @* begin
		zt_sum = {t_m1[17], t_m1} + 19'sh08000;
		if (zt_sum > 19'sh1ffff) begin
			next_zt = `SCM_MAX;
			zt_sat = 1'b1;
		end else if (zt_sum < 19'sh00000) begin
			next_zt = 18'sh00000;
			zt_sat = 1'b1;
		end else begin
			next_zt = zt_sum[17:0];
			zt_sat = 1'b0;
		end
	end
	// ************************************
	// Sequencer
	// ************************************
	always @* begin
		case (step)
			`SCM_ST_IDLE: next_step = (bridge_valid && temp_valid) ? 4'h1 : `SCM_ST_IDLE;
			`SCM_ST_LAST: next_step = `SCM_ST_IDLE;
			default:      next_step = step + 4'h1;
		endcase
	end
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			step <= `SCM_ST_IDLE;
			delta_t <= 18'sh00000;
			gain_drift_factor <= 18'sh00000;
			offset_corrected_bridge <= 18'sh00000;
			acc <= 18'sh00000;
			bridge_stage_one_value <= 18'sh00000;
			zt <= 18'sh00000;
			sat_b <= 1'b0;
			sat_t <= 1'b0;
			done <= 1'b0;
			bridge_out <= 16'h0000;
			bridge_status <= `SCM_STAT_RST;
			temp_out <= 17'h00000;
			temp_status <= `SCM_STAT_RST;
		end else if (clk_en) begin
			step <= next_step;
			done <= 1'b0;
			case (step)
				`SCM_ST_IDLE: begin
					sat_b <= 1'b0;
					sat_t <= 1'b0;
				end
				4'h1: begin
					delta_t <= step_res;
					zt <= next_zt;
					sat_t <= t_sat_a | t_s1 | zt_sat;
				end
				4'h3: gain_drift_factor <= step_res;
				4'h6: offset_corrected_bridge <= step_res;
				4'h8: bridge_stage_one_value <= step_res;
				default: acc <= step_res;
			endcase
			if (step != `SCM_ST_IDLE) begin
				sat_b <= sat_b | step_sat;
			end
			if (step == `SCM_ST_LAST) begin
				// Top of S-curve range is 10000, which would wrap 16 bits
				bridge_out <= (step_res > 18'sh0ffff) ? `SCM_OUT_MAX : step_res[15:0];
				bridge_status <= {7'h00, sat_b | step_sat};
				temp_out <= t_fin[16:0];
				temp_status <= {7'h00, sat_t | t_s2 | t_sat_q | t_s3};
				done <= 1'b1;
			end
		end
	end
endmodule

// ---- design/scm_sat_mul.v ----
`include "scm_defines.vh"
// ************************************
// Scaled multiply with clamp
// ************************************
module scm_sat_mul (
	// Operands
	input  wire signed [17:0] op_a,
	input  wire signed [17:0] op_b,
	input  wire signed [17:0] lo_lim,
	input  wire signed [17:0] hi_lim,
	input  wire               do_shift,
	// Result
	output reg  signed [17:0] res,
	output reg                sat
);
	reg signed [35:0] prod;
	reg signed [35:0] scaled;
	always @* begin
		prod   = op_a * op_b;
		// Arithmetic shift keeps sign before the clamp check
		scaled = do_shift ? (prod >>> `SCM_SHIFT) : prod;
		// Concatenations are unsigned; re-sign so the compare stays signed
		if (scaled > $signed({{18{hi_lim[17]}}, hi_lim})) begin
			res = hi_lim;
			sat = 1'b1;
		end else if (scaled < $signed({{18{lo_lim[17]}}, lo_lim})) begin
			res = lo_lim;
			sat = 1'b1;
		end else begin
			res = scaled[17:0];
			sat = 1'b0;
		end
	end
endmodule

// ---- inc/scm_defines.vh ----
`ifndef SCM_DEFINES_VH
`define SCM_DEFINES_VH
// ************************************
// Datapath widths and limits
// ************************************
`define SCM_W          18
`define SCM_SHIFT      15
`define SCM_HALF       18'sh08000
`define SCM_MAX        18'sh1ffff
`define SCM_MIN        -18'sh20000
`define SCM_B_MAX      18'sh10000
`define SCM_OUT_MAX    16'hffff
// ************************************
// Status layout and reset values
// ************************************
`define SCM_STAT_SAT   0
`define SCM_STAT_RST   8'h00
// ************************************
// Sequencer step codes
// ************************************
`define SCM_ST_IDLE    4'h0
`define SCM_ST_LAST    4'ha
`endif

// ---- testbench/scm_correction_math_properties.sv ----
// ****************
// Port checker
// ****************
module scm_math_checker (
	// Clock and control
	input wire               ref_clk,
	input wire               reset_n,
	input wire               clk_en,
	input wire               bridge_valid,
	input wire               temp_valid,
	input wire               curve_shape_select,
	// Coefficients
	input wire signed [17:0] gain_b,
	input wire signed [17:0] gain_t,
	input wire signed [17:0] temp_quad_coef,
	// Results
	input wire               busy,
	input wire               done,
	input wire        [15:0] bridge_out,
	input wire        [7:0]  bridge_status,
	input wire        [16:0] temp_out,
	input wire        [7:0]  temp_status
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	wire take = clk_en && !busy && bridge_valid && temp_valid;
	// Enabled edges since the taking edge; frozen edges do not count
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			cnt <= 4'h0;
		else if (take)
			cnt <= 4'h1;
		else if (done && clk_en)
			cnt <= 4'h0;
		else if (clk_en && cnt != 4'h0 && cnt != 4'hc)
			cnt <= cnt + 4'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_take;
		clk_en && !busy && bridge_valid && temp_valid;
	endsequence
	sequence s_hold;
		busy [*8];
	endsequence
	AST_BUSY_HOLD: assert property (s_take |=> s_hold)
		else $error("busy fell early");
	// Done is seen at the eleventh enabled edge after the taking edge
	AST_LATENCY: assert property (done |-> cnt == 4'hb)
		else $error("done at wrong edge");
	AST_DUE: assert property (cnt == 4'hb |-> done)
		else $error("done missing");
	AST_DONE_PULSE: assert property (done && clk_en |=> !done)
		else $error("done too long");
	AST_IDLE_AT_DONE: assert property (done |-> !busy)
		else $error("busy at done");
	AST_OUT_HOLD: assert property ($changed(bridge_out) || $changed(temp_out)
		|| $changed(bridge_status) || $changed(temp_status) |-> done)
		else $error("result moved without done");
	AST_S_MID: assert property (done && curve_shape_select && gain_b == 18'sh0
		|-> bridge_out == 16'h8000)
		else $error("s-curve zero gain not mid");
	AST_T_MID: assert property (done && gain_t == 18'sh0 && temp_quad_coef == 18'sh0
		|-> temp_out == 17'h08000)
		else $error("temp zero gain not mid");
	AST_STAT_RSVD: assert property (done |-> bridge_status[7:1] == 7'h0
		&& temp_status[7:1] == 7'h0)
		else $error("status spare bits set");
endmodule
bind scm_correction_math scm_math_checker i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.clk_en(clk_en), .bridge_valid(bridge_valid), .temp_valid(temp_valid),
	.curve_shape_select(curve_shape_select), .gain_b(gain_b), .gain_t(gain_t),
	.temp_quad_coef(temp_quad_coef), .busy(busy), .done(done), .bridge_out(bridge_out),
	.bridge_status(bridge_status), .temp_out(temp_out), .temp_status(temp_status));

// ---- testbench/scm_src_model.sv ----
// ****************
// Reading source
// ****************
module scm_src_model (
	// Clock and reset
	input  wire               ref_clk,
	input  wire               reset_n,
	// Bench side
	input  wire               req,
	input  wire        [3:0]  lag,
	input  wire signed [17:0] rb_in,
	input  wire signed [17:0] rt_in,
	// Datapath side
	input  wire               done,
	output wire               bridge_valid,
	output wire               temp_valid,
	output wire signed [17:0] raw_bridge,
	output wire signed [17:0] raw_temp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic               bv, tv, hold;
	logic        [3:0]  cnt;
	logic signed [17:0] rb, rt;
	// Valids fall with req, so a finished run is not taken twice
	assign bridge_valid = bv && req;
	assign temp_valid   = tv && req;
	// Released lines show the inverse, not the old reading
	assign raw_bridge = hold ? rb : ~rb;
	assign raw_temp   = hold && tv ? rt : ~rt;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{bv, tv, hold, cnt, rb, rt} <= '0;
		end else if (!req) begin
			bv <= 1'b0;
			tv <= 1'b0;
			hold <= hold && !done;
		end else if (!bv) begin
			bv <= 1'b1;
			hold <= 1'b1;
			rb <= rb_in;
			rt <= rt_in;
			cnt <= lag;
		end else if (!tv) begin
			tv <= cnt == 4'h0;
			cnt <= cnt - 4'h1;
		end
	end
endmodule

// ---- testbench/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic               ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, req = 1'b0;
	logic               curve = 1'b0, en_rand = 1'b0, ebs, ets, bv, tv, busy, done;
	logic        [3:0]  lag = 4'h0;
	logic signed [17:0] rb_in = 0, rt_in = 0, gb = 0, ob = 0, tcg = 0, tco = 0, tref = 0;
	logic signed [17:0] sgq = 0, soq = 0, bq = 0, gt = 0, ot = 0, tq = 0, rbr, rtr;
	logic        [15:0] bridge_out, eb;
	logic        [16:0] temp_out, et;
	logic        [7:0]  bridge_status, temp_status;
	bit                 sat;
	int                 mismatches = 0;
	int                 num_checks = 0;
	scm_src_model i_scm_src_model (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
		.lag(lag), .rb_in(rb_in), .rt_in(rt_in), .done(done), .bridge_valid(bv),
		.temp_valid(tv), .raw_bridge(rbr), .raw_temp(rtr));
	scm_correction_math i_scm_correction_math (.ref_clk(ref_clk), .reset_n(reset_n),
		.clk_en(clk_en), .raw_bridge(rbr), .bridge_valid(bv), .raw_temp(rtr),
		.temp_valid(tv), .curve_shape_select(curve), .gain_b(gb), .offset_b(ob),
		.tc_gain(tcg), .tc_offset(tco), .low_cal_temperature_ref(tref),
		.gain_drift_quad_coef(sgq), .offset_drift_quad_coef(soq), .bridge_quad_coef(bq),
		.gain_t(gt), .offset_t(ot), .temp_quad_coef(tq), .busy(busy), .done(done),
		.bridge_out(bridge_out), .bridge_status(bridge_status), .temp_out(temp_out),
		.temp_status(temp_status));
	initial forever #5 ref_clk = ~ref_clk;
	// Random freezes stretch the run without changing results
	always @(negedge ref_clk) clk_en <= en_rand ? $urandom_range(3) != 0 : 1'b1;
	function automatic longint cl(longint v, longint lo = -131072, longint hi = 131071);
		if (v < lo || v > hi)
			sat = 1'b1;
		return v < lo ? lo : v > hi ? hi : v;
	endfunction
	function automatic longint ml(longint a, longint b);
		return (a * b) >>> 15;
	endfunction
	function automatic logic signed [17:0] rnd(int lo, int hi);
		return 18'(lo + int'($urandom_range(hi - lo)));
	endfunction
	task automatic predict;
		longint dt, k1, k2, z, b;
		sat = 1'b0;
		dt = cl(longint'(rt_in) - tref);
		k1 = cl(32768 + cl(ml(dt, cl(cl(ml(sgq, dt)) + tcg))));
		k2 = cl(ob + cl(longint'(rb_in) + cl(ml(dt, cl(cl(ml(soq, dt)) + tco)))));
		z = cl(ml(gb, cl(ml(k1, k2))));
		if (!curve) begin
			z = cl(z + 32768, 0);
			b = cl(ml(z, cl(cl(ml(bq, z)) + 32768)), 0);
		end else begin
			b = cl(ml(z, cl(cl(ml(bq, z < 0 ? -z : z)) + 32768)) + 32768, 0, 65536);
		end
		eb = b > 65535 ? 16'hffff : b[15:0];
		ebs = sat;
		sat = 1'b0;
		z = cl(cl(ml(gt, cl(longint'(rt_in) + ot))) + 32768, 0);
		b = cl(ml(z, cl(cl(ml(tq, z)) + 32768)), 0);
		et = b[16:0];
		ets = sat;
	endtask
	task automatic chk(bit ok, string what);
		num_checks++;
		if (!ok) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	task automatic run(int id, bit b2b);
		int n;
		predict();
		@(negedge ref_clk);
		while (done === 1'b1)
			@(negedge ref_clk);
		req = 1'b1;
		for (int rep = 0; rep <= b2b; rep++) begin
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
				if (bv === 1'b1 && tv !== 1'b1)
					chk(busy === 1'b0, "early start");
			end while (done !== 1'b1 && n < 400);
			if (rep == b2b)
				req = 1'b0;
			chk(done === 1'b1, "no done");
			chk(bridge_out === eb, "bridge result");
			chk(bridge_status === {7'h0, ebs}, "bridge status");
			chk(temp_out === et, "temp result");
			chk(temp_status === {7'h0, ets}, "temp status");
			// A frozen edge can stretch done; wait it out before moving on
			while (done === 1'b1)
				@(negedge ref_clk);
		end
		$display("test %0d end: bridge %h temp %h", id, bridge_out, temp_out);
	endtask
	// Odd runs span wide ranges, full for readings and gains, even runs stay near unity gain
	task automatic pick(bit f);
		curve = $urandom_range(1);
		lag = $urandom_range(15);
		en_rand = $urandom_range(1);
		rb_in = f ? rnd(-131071, 131071) : rnd(-16384, 16384);
		rt_in = f ? rnd(-131071, 131071) : rnd(-16384, 16384);
		gb = f ? rnd(-131071, 131071) : rnd(24576, 40960);
		ob = f ? rnd(-131071, 131071) : rnd(-4096, 4096);
		tcg = f ? rnd(-131071, 131071) : rnd(-2048, 2048);
		tco = f ? rnd(-131071, 131071) : rnd(-2048, 2048);
		tref = f ? rnd(-4095, 65535) : rnd(-4095, 4095);
		sgq = f ? rnd(-8191, 8191) : rnd(-255, 255);
		soq = f ? rnd(-8191, 8191) : rnd(-255, 255);
		bq = f ? rnd(-8191, 131071) : rnd(-2047, 2047);
		gt = f ? rnd(-131071, 131071) : rnd(24576, 40960);
		ot = f ? rnd(-8191, 131071) : rnd(-4096, 4096);
		tq = f ? rnd(-131071, 131071) : rnd(-2047, 2047);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hcd3e));
		repeat (20) @(negedge ref_clk);
		reset_n = 1'b1;
		curve = 1'b1;
		run(0, 1'b1);
		for (int s = 0; s < 4; s++) begin
			curve = s[0];
			{gb, ob, tcg, tco, gt, tq, rb_in, rt_in} = s[1] ? {8{-18'sh1ffff}} : {8{18'sh1ffff}};
			tref = s[1] ? -18'sh0fff : 18'sh0ffff;
			{sgq, soq} = s[1] ? {2{-18'sh1fff}} : {2{18'sh1fff}};
			{bq, ot} = s[1] ? {2{-18'sh1fff}} : {2{18'sh1ffff}};
			run(s + 1, s == 3);
		end
		for (int k = 5; k < 60; k++) begin
			pick(k[0]);
			run(k, k % 8 == 0);
		end
		final_report();
	end
	// Sixty runs need a few thousand cycles
	initial begin
		#400000;
		mismatches++;
		$display("[ERR] %0t watchdog", $time);
		final_report();
	end
endmodule
